// ### rtl/cat_regs.vh
// Register offsets, field positions, reset values and response codes of the CA termination block.
`ifndef CAT_REGS_VH
`define CAT_REGS_VH
`define CAT_CFG_OFFSET 4'h0
`define CAT_STATUS_OFFSET 4'h4
`define CAT_CAL_OFFSET 4'h8
`define CAT_RTT_LSB 4
`define CAT_RTT_MSB 6
`define CAT_PU_BIT 0
`define CAT_PD_BIT 0
`define CAT_SR_BIT 1
`define CAT_RTT_OFF 3'h0
`define CAT_CFG_RESET 32'h00000000
`define CAT_CAL_RESET 32'h00000000
`define CAT_RESP_OKAY 2'h0
`define CAT_RESP_SLVERR 2'h2
`endif

// ### rtl/cat_sync.v
// Two-flop synchroniser for one level from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none
module cat_sync (
    input wire aclk,
    input wire aresetn,
    input wire async_in,
    output reg sync_out
);
    reg meta_q;

    // The first stage feeds only the second stage.
    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // cat_sync
`default_nettype wire

// ### rtl/cat_ca_term.v
// CA bus termination control with an AXI4-Lite register slave.
//
// Overview of operation
// - The termination resistance comes from the three-bit field at bits 6:4 of the config register.
// - After reset termination is off until software writes a termination value.
// - When on, termination covers both clock legs, chip select and all six CA inputs.
// - Termination stays on through power-down and self-refresh power-down.
// - With the captured strap low the bus is never terminated, whatever the field holds.
// - With the captured strap high and a nonzero field the bus is terminated at the programmed value.
// - Power-down entry never changes the captured strap state.
// - A termination value change after calibration is accepted with no new calibration.
`timescale 1ns/100ps
`default_nettype none
`include "cat_regs.vh"
module cat_ca_term (
    input wire aclk,
    input wire aresetn,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire ca_termination_strap,
    input wire power_down,
    input wire self_refresh,
    output reg term_ck_t_q,
    output reg term_ck_c_q,
    output reg term_cs_q,
    output reg [5:0] term_ca_q,
    output reg [2:0] term_rtt_q
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    wire strap_sync;
    wire pd_sync;
    wire sr_sync;

    cat_sync u_strap (.aclk(aclk), .aresetn(aresetn), .async_in(ca_termination_strap),
        .sync_out(strap_sync));
    cat_sync u_pd (.aclk(aclk), .aresetn(aresetn), .async_in(power_down),
        .sync_out(pd_sync));
    cat_sync u_sr (.aclk(aclk), .aresetn(aresetn), .async_in(self_refresh),
        .sync_out(sr_sync));

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg [2:0] rtt_q;
    reg pu_point_q;
    reg strap_q;
    reg aw_have_q;
    reg w_have_q;
    reg [3:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    wire term_on;

    // Strap is followed only while not powered down; entry freezes it.
    // Self-refresh freezes it too, being the deeper of the two power states, so a rank
    // that sees its strap move in either state cannot drop the shared bus load.
    always @(posedge aclk) begin
        if (!aresetn) begin
            strap_q <= 1'b0;
        end else if (!pd_sync && !sr_sync) begin
            strap_q <= strap_sync;
        end
    end

    // Strap gates everything; zero field means off. Power state is not an input.
    // Leaving power state out is deliberate: termination must survive both sleep states.
    assign term_on = strap_q && (rtt_q != `CAT_RTT_OFF);

    // Termination outputs are registered; all pins share one enable.
    always @(posedge aclk) begin
        if (!aresetn) begin
            term_ck_t_q <= 1'b0;
            term_ck_c_q <= 1'b0;
            term_cs_q <= 1'b0;
            term_ca_q <= 6'h00;
            term_rtt_q <= 3'h0;
        end else begin
            term_ck_t_q <= term_on;
            term_ck_c_q <= term_on;
            term_cs_q <= term_on;
            term_ca_q <= {6{term_on}};
            term_rtt_q <= term_on ? rtt_q : `CAT_RTT_OFF;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    // Address and data are captured independently, so either may come first.
    // Each ready is a registered pulse that rests for one cycle after it was high.
    // The rest halves peak throughput, which costs nothing for a few set-up writes,
    // and in exchange every handshake output comes straight from a flop.
    wire wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CAT_RESP_OKAY;
            rtt_q <= `CAT_RTT_OFF;
            pu_point_q <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_awready;
            s_axi_wready <= !w_have_q && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `CAT_RESP_OKAY;
                case (awaddr_q)
                    `CAT_CFG_OFFSET: begin
                        // New value takes effect directly; no calibration needed.
                        // A clear lowest strobe leaves the field as it was.
                        if (wstrb_q[0]) begin
                            rtt_q <= wdata_q[`CAT_RTT_MSB:`CAT_RTT_LSB];
                        end
                    end
                    `CAT_CAL_OFFSET: begin
                        // The point is only stored; rerunning calibration after a change is
                        // up to the controller, as this block has no calibration engine.
                        if (wstrb_q[0]) begin
                            pu_point_q <= wdata_q[`CAT_PU_BIT];
                        end
                    end
                    `CAT_STATUS_OFFSET: begin
                        // Status is read-only: the write is answered and dropped.
                        s_axi_bresp <= `CAT_RESP_OKAY;
                    end
                    default: begin
                        // Unmapped offsets answer with an error and change nothing.
                        s_axi_bresp <= `CAT_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    // Status shows live state, so software can see what the pins are doing.
    // Only one read is under way: arready rests while a response waits for rready,
    // so the read data register cannot be overwritten before it is taken.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CAT_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `CAT_RESP_OKAY;
                case (s_axi_araddr)
                    `CAT_CFG_OFFSET: begin
                        s_axi_rdata <= {25'h0000000, rtt_q, 4'h0};
                    end
                    `CAT_STATUS_OFFSET: begin
                        s_axi_rdata <= {24'h000000, term_on, term_rtt_q, sr_sync, pd_sync,
                            strap_q, term_cs_q};
                    end
                    `CAT_CAL_OFFSET: begin
                        s_axi_rdata <= {31'h00000000, pu_point_q};
                    end
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `CAT_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // cat_ca_term
`default_nettype wire

// ### verification/cat_ctl_model.sv
// Controller-side model: rank strap wiring and power-state requests.
`timescale 1ns/100ps
`default_nettype none
module cat_ctl_model (
    input wire logic aclk,
    input wire logic [1:0] req,
    input wire logic rank0,
    output logic strap,
    output var logic [1:0] pwr
);
    // Only the terminating rank sees a high strap, so one load sits on the bus.
    assign strap = rank0;
    // Power levels move just after an edge, as a controller issues them.
    initial pwr = 2'h0;
    always @(posedge aclk) begin
        pwr <= req;
    end
endmodule // cat_ctl_model
`default_nettype wire

// ### verification/cat_term_monitor.sv
// Checker for the CA termination block, bound to its top module.
`timescale 1ns/100ps
`default_nettype none
module cat_term_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ca_termination_strap,
    input wire logic power_down,
    input wire logic self_refresh,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic term_ck_t_q,
    input wire logic term_ck_c_q,
    input wire logic term_cs_q,
    input wire logic [5:0] term_ca_q,
    input wire logic [2:0] term_rtt_q
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic wrote_q;
    // Remembers any write response; a pin cannot terminate before one.
    always @(posedge aclk) begin
        if (!aresetn) wrote_q <= 1'h0;
        else if (s_axi_bvalid) wrote_q <= 1'h1;
    end
    // Power-down held long enough for its synchroniser and the strap freeze to settle.
    sequence s_pd_held;
        power_down [*8];
    endsequence
    // Both clock legs, chip select and every CA lane share one enable.
    a_legs_agree: assert property (
        term_ck_t_q == term_cs_q && term_ck_c_q == term_cs_q)
        else $error("clock legs differ from cs");
    a_ca_lanes_all: assert property (
        term_ca_q == {6{term_cs_q}})
        else $error("ca lanes differ");
    a_zero_is_off: assert property (
        (term_rtt_q == 3'h0) ##1 (term_rtt_q == 3'h0) |-> !term_cs_q)
        else $error("on with zero code");
    // Six quiet samples outlast the strap synchroniser and the output register.
    a_strap_low_off: assert property (
        (!ca_termination_strap && !power_down && !self_refresh) [*6] |-> !term_cs_q)
        else $error("on with strap low");
    a_pd_keeps_on: assert property (
        s_pd_held ##0 (term_cs_q && !s_axi_bvalid && !$past(s_axi_bvalid)) |=> term_cs_q)
        else $error("dropped in power-down");
    a_off_till_write: assert property (
        term_cs_q |-> wrote_q)
        else $error("on before any write");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("late read answer");
    a_read_holds: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule // cat_term_monitor
bind cat_ca_term cat_term_monitor mon (.aclk(aclk), .aresetn(aresetn),
    .ca_termination_strap(ca_termination_strap), .power_down(power_down),
    .self_refresh(self_refresh), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .term_ck_t_q(term_ck_t_q), .term_ck_c_q(term_ck_c_q),
    .term_cs_q(term_cs_q), .term_ca_q(term_ca_q), .term_rtt_q(term_rtt_q));
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the CA termination block.
`timescale 1ns/100ps
`default_nettype none
`include "cat_regs.vh"
module testbench;
    logic aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, brd = 1'h0, arv = 1'h0;
    logic rrd = 1'h0, strap_en = 1'h0, strap, awr, wrdy, bv, arr, rv, tckt, tckc, tcs;
    logic [3:0] awa = 4'h0, ara = 4'h0;
    logic [3:0] ws = 4'hF;
    logic slow = 1'h0;
    logic [31:0] wd = 32'h0, rd;
    logic [1:0] req = 2'h0, br, rr, pwr;
    logic [5:0] tca;
    logic [2:0] trtt;
    integer err_count = 0, checks_done = 0, cyc = 0, v;
    always #20 aclk = ~aclk;
    cat_ca_term DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrd), .ca_termination_strap(strap),
        .power_down(pwr[0]), .self_refresh(pwr[1]), .term_ck_t_q(tckt), .term_ck_c_q(tckc),
        .term_cs_q(tcs), .term_ca_q(tca), .term_rtt_q(trtt));
    cat_ctl_model ctl (.aclk(aclk), .req(req), .rank0(strap_en), .strap(strap), .pwr(pwr));
    task chk(input string nm, input [31:0] e, input [31:0] g);
        checks_done++;
        if (e !== g) begin
            err_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // Address and data go out together; each drops once its own ready is seen.
    task axw(input [3:0] a, input [31:0] d, input [1:0] er);
        @(posedge aclk);
        awa <= a;
        wd <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        brd <= 1'h1;
        do begin
            @(posedge aclk);
            if (awr) awv <= 1'h0;
            if (wrdy) wv <= 1'h0;
        end while (bv !== 1'h1);
        brd <= 1'h0;
        chk("bresp", er, br);
    endtask
    // With slow set, rready comes one cycle after rvalid, so a waiting response is seen.
    task axr(input [3:0] a, input [31:0] ed, input [1:0] er);
        @(posedge aclk);
        ara <= a;
        arv <= 1'h1;
        rrd <= !slow;
        do begin
            @(posedge aclk);
            if (arr) arv <= 1'h0;
            if (rv && !rrd) rrd <= 1'h1;
        end while (rv !== 1'h1 || rrd !== 1'h1);
        rrd <= 1'h0;
        chk("rdata", ed, rd);
        chk("rresp", er, rr);
    endtask
    // Eight cycles cover the strap synchroniser plus the output register.
    task term(input on, input [2:0] c);
        repeat (8) @(posedge aclk);
        chk("term", on ? {c, 9'h1FF} : 12'h0, {trtt, tckt, tckc, tcs, tca});
    endtask
    task final_report;
        if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_count++;
            final_report;
        end
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        strap_en <= 1'h1;
        term(1'h0, 3'h0);
        for (v = 0; v < 8; v++) begin
            axw(`CAT_CFG_OFFSET, v << 4, `CAT_RESP_OKAY);
            term(v != 0, v[2:0]);
        end
        axr(`CAT_CFG_OFFSET, 32'h70, `CAT_RESP_OKAY);
        strap_en <= 1'h0;
        term(1'h0, 3'h0);
        axw(`CAT_CFG_OFFSET, 32'h30, `CAT_RESP_OKAY);
        strap_en <= 1'h1;
        term(1'h1, 3'h3);
        req <= 2'h1;
        repeat (6) @(posedge aclk);
        strap_en <= 1'h0;
        term(1'h1, 3'h3);
        req <= 2'h2;
        term(1'h1, 3'h3);
        req <= 2'h0;
        term(1'h0, 3'h0);
        strap_en <= 1'h1;
        // The calibration write and the config write go one at a time; each waits for its response first.
        axw(`CAT_CAL_OFFSET, 32'h1, `CAT_RESP_OKAY);
        axw(`CAT_CFG_OFFSET, 32'h10, `CAT_RESP_OKAY);
        term(1'h1, 3'h1);
        axw(4'hC, 32'h50, `CAT_RESP_SLVERR);
        axr(4'hC, 32'h0, `CAT_RESP_SLVERR);
        slow <= 1'h1;
        axr(`CAT_CAL_OFFSET, 32'h1, `CAT_RESP_OKAY);
        slow <= 1'h0;
        term(1'h1, 3'h1);
        axw(`CAT_STATUS_OFFSET, 32'hFF, `CAT_RESP_OKAY);
        axr(`CAT_STATUS_OFFSET, 32'h93, `CAT_RESP_OKAY);
        ws <= 4'hE;
        axw(`CAT_CFG_OFFSET, 32'h50, `CAT_RESP_OKAY);
        ws <= 4'hF;
        term(1'h1, 3'h1);
        final_report;
    end
endmodule // testbench
`default_nettype wire
